// file: rtl/cdi_host_port.sv
// card detect, interrupt and status port toward the host controller
`timescale 1ns/100ps

// Overview of operation
// - debounce detect input, then pull interrupt low
// - fifty microsecond filter on insertion and extraction
// - rising or falling detect edge per polarity
// - default normally open, falling edge inserts
// - interrupt released on next select rising edge following a fall with interrupt low
// - status high when card present, else low
// - programming accepted with card supply on or off
// - programming mode latched on select falling edge
// - battery and converter results share status output
// - interrupt level never affects device operation
// - one read clears interrupt and returns status
// - address and programming data captured on select rising edge
// - address and program select choose status source
module cdi_host_port
    import cdi_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host control pins
    input wire logic unit_select_n,
    input wire logic program_select_n,
    input wire logic status_sel_lo,
    input wire logic status_sel_hi,
    input wire logic prog_data_in,
    // analog monitor results
    input wire logic battery_ok_in,
    input wire logic converter_ok_in,
    // card side switch
    input wire logic card_presence_switch_in,
    // host outputs
    output logic irq_n,
    output logic status_out,
    output logic card_present_out
);

    // synchronised pin vector
    logic [PIN_W-1:0] pins_raw; // pins gathered for the synchroniser
    logic [PIN_W-1:0] pins; // filtered, on ref_clk

    // short names for the synchronised pins
    logic cs_n; // unit select, active low
    logic pgm_n; // program select, active low
    logic [1:0] sel_now; // live status address
    logic prog_data; // programming data bit
    logic batt_ok; // battery check result
    logic conv_ok; // converter operating result

    // debounced card switch
    logic card_level; // stable switch level
    logic card_event; // one-cycle pulse on insertion or extraction

    // host access state
    cdi_host_state_t state;
    cdi_host_state_t next_state;
    logic cs_prev; // select one cycle back, for edges
    logic cs_fall; // select falling edge
    logic cs_rise; // select rising edge

    // captured and programmed values
    logic [1:0] captured_sel; // address taken at the last rising edge
    logic [1:0] next_captured_sel;
    logic polarity; // 1 = rising edge inserts
    logic next_polarity;

    // interrupt handshake
    logic ack_armed; // select went low while interrupt pending
    logic next_ack_armed;
    logic next_irq_n;

    // status path
    logic card_present; // presence after polarity
    logic next_status_out;
    logic next_card_present_out;

    // status source selection, shared by live and captured addresses;
    // codes other than battery and converter fall back to presence, so
    // an unused address still reads something meaningful
    function automatic logic cdi_status_pick(
        input logic [1:0] sel,
        input logic present,
        input logic batt,
        input logic conv
    );
        logic pick;
        pick = present;
        if (sel == SEL_BATTERY) begin
            pick = batt;
        end else if (sel == SEL_CONVERTER) begin
            pick = conv;
        end else begin
            pick = present; // presence on the remaining codes
        end
        return pick;
    endfunction : cdi_status_pick

    // gather pins in the package order; the order must match PIN_RST_VAL
    // so that each synchroniser flop resets to the idle level of its pin
    always_comb begin
        pins_raw = '0;
        pins_raw[PIN_CS_N] = unit_select_n;
        pins_raw[PIN_PGM_N] = program_select_n;
        pins_raw[PIN_SEL_LO] = status_sel_lo;
        pins_raw[PIN_SEL_HI] = status_sel_hi;
        pins_raw[PIN_PROG_DATA] = prog_data_in;
        pins_raw[PIN_BATT_OK] = battery_ok_in;
        pins_raw[PIN_CONV_OK] = converter_ok_in;
        pins_raw[PIN_CARD_SW] = card_presence_switch_in;
    end

    // every pin is asynchronous to ref_clk; a pin change reaches the logic
    // four edges later, and select edges need two cycles between them
    cdi_pin_sync #(
        .W(PIN_W),
        .RST_VAL(PIN_RST_VAL)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(pins_raw),
        .pin_out(pins)
    );

    // unpack synchronised pins
    always_comb begin
        cs_n = pins[PIN_CS_N];
        pgm_n = pins[PIN_PGM_N];
        sel_now = {pins[PIN_SEL_HI], pins[PIN_SEL_LO]};
        prog_data = pins[PIN_PROG_DATA];
        batt_ok = pins[PIN_BATT_OK];
        conv_ok = pins[PIN_CONV_OK];
    end

    // the switch is filtered before anything looks at it
    cdi_debounce u_debounce (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(pins[PIN_CARD_SW]),
        .level(card_level),
        .changed(card_event)
    );

    // select edges from the accepted select level; a raw glitch that the
    // synchroniser never accepts produces no edge at all
    always_comb begin
        cs_fall = cs_prev & ~cs_n;
        cs_rise = ~cs_prev & cs_n;
    end

    // presence follows the programmed polarity; a reprogram flips the
    // reading but raises no interrupt, since only switch edges do
    always_comb begin
        card_present = ~(card_level ^ polarity);
    end

    // host access sequencing; the mode is decided once per select cycle,
    // a program select change while selected waits for the next fall
    always_comb begin
        next_state = state;
        case (state)
            HOST_IDLE: begin
                if (cs_fall) begin
                    // mode fixed here; program select may rise later
                    next_state = pgm_n ? HOST_NORMAL : HOST_PROG;
                end
            end
            HOST_NORMAL: begin
                if (cs_rise) begin
                    next_state = HOST_IDLE;
                end
            end
            HOST_PROG: begin
                if (cs_rise) begin
                    next_state = HOST_IDLE;
                end
            end
            default: begin
                next_state = HOST_IDLE;
            end
        endcase
    end

    // capture and programming on the select rising edge; programming
    // accesses to any other address pass without touching the polarity
    always_comb begin
        next_captured_sel = captured_sel;
        next_polarity = polarity;
        if (cs_rise && state != HOST_IDLE) begin
            next_captured_sel = sel_now;
            // no card supply term here: programming works powered or not
            if (state == HOST_PROG && sel_now == PROG_ADDR_POLARITY) begin
                next_polarity = prog_data;
            end
        end
    end

    // interrupt: set on a debounced event, released after a select cycle;
    // limitation: a select fall seen before irq_n drops does not arm, so
    // an access already under way cannot acknowledge a fresh event
    always_comb begin
        next_irq_n = irq_n;
        next_ack_armed = ack_armed;
        if (cs_fall && !irq_n) begin
            next_ack_armed = 1'b1;
        end
        if (cs_rise && ack_armed) begin
            // the same select cycle may also read status
            next_irq_n = 1'b1;
            next_ack_armed = 1'b0;
        end
        if (card_event) begin
            // a new event wins over a release in the same cycle and
            // needs its own select cycle to be acknowledged
            next_irq_n = 1'b0;
            next_ack_armed = 1'b0;
        end
    end

    // status output: live address while selected in normal mode,
    // captured address once deselected, held in programming mode;
    // trade-off: the captured source keeps tracking its live input, so a
    // later battery change shows without a new access
    always_comb begin
        next_status_out = status_out;
        next_card_present_out = card_present;
        case (state)
            HOST_NORMAL: begin
                if (!cs_n) begin
                    next_status_out = cdi_status_pick(sel_now, card_present,
                        batt_ok, conv_ok);
                end
            end
            HOST_IDLE: begin
                next_status_out = cdi_status_pick(captured_sel, card_present,
                    batt_ok, conv_ok);
            end
            HOST_PROG: begin
                next_status_out = status_out; // untouched while programming
            end
            default: begin
                next_status_out = status_out;
            end
        endcase
    end

    // select sequencing registers; cs_prev resets to the idle select
    // level so that no false edge follows reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= HOST_IDLE;
            cs_prev <= PIN_RST_VAL[PIN_CS_N];
        end else begin
            state <= next_state;
            cs_prev <= cs_n;
        end
    end

    // captured address and programmed polarity; the polarity survives
    // every select cycle that does not address it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            captured_sel <= SEL_PRESENCE;
            polarity <= POLARITY_RST;
        end else begin
            captured_sel <= next_captured_sel;
            polarity <= next_polarity;
        end
    end

    // irq_n drives only the pin; no logic here reads it besides its own
    // handshake, so it cannot disturb card activity
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_armed <= 1'b0;
            irq_n <= 1'b1; // released: no event seen yet
        end else begin
            ack_armed <= next_ack_armed;
            irq_n <= next_irq_n;
        end
    end

    // status pins; both come from flops so the host never sees a glitch
    // while the sources settle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_out <= STATUS_RST;
            card_present_out <= 1'b0;
        end else begin
            status_out <= next_status_out;
            card_present_out <= next_card_present_out;
        end
    end

endmodule : cdi_host_port

// file: rtl/cdi_pkg.sv
// shared constants and types for the card detect interrupt host port
package cdi_pkg;

    // clock and debounce timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEBOUNCE_NS = 50000;
    localparam int DEBOUNCE_CNT_W = 10;
    // least time rounds up to whole cycles
    localparam logic [DEBOUNCE_CNT_W-1:0] DEBOUNCE_CYCLES =
        DEBOUNCE_CNT_W'((DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // positions inside the synchronised pin vector
    localparam int PIN_W = 8;
    localparam int PIN_CS_N = 0;
    localparam int PIN_PGM_N = 1;
    localparam int PIN_SEL_LO = 2;
    localparam int PIN_SEL_HI = 3;
    localparam int PIN_PROG_DATA = 4;
    localparam int PIN_BATT_OK = 5;
    localparam int PIN_CONV_OK = 6;
    localparam int PIN_CARD_SW = 7;
    // pin reset values: select idle high, switch open (pulled up)
    localparam logic [PIN_W-1:0] PIN_RST_VAL = 8'h83;

    // status output selection codes {sel_hi, sel_lo}
    localparam logic [1:0] SEL_PRESENCE = 2'h0;
    localparam logic [1:0] SEL_BATTERY = 2'h1;
    localparam logic [1:0] SEL_CONVERTER = 2'h2;
    // programming address that loads the detect polarity
    localparam logic [1:0] PROG_ADDR_POLARITY = 2'h3;

    // detect polarity: 0 = normally open, insertion on falling edge
    localparam logic POLARITY_RST = 1'b0;
    localparam logic STATUS_RST = 1'b0;

    // host access states
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_NORMAL = 2'b01,
        HOST_PROG = 2'b10
    } cdi_host_state_t;

endpackage : cdi_pkg

// file: rtl/cdi_pin_sync.sv
// three-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module cdi_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // pins and filtered result
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);

    logic [W-1:0] stage1; // only read by stage2
    logic [W-1:0] stage2; // second flop
    logic [W-1:0] stage3; // third flop
    logic [W-1:0] next_out; // accepted value

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // a change counts only once stages two and three agree
            always_comb begin
                next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_out[i];
            end
        end
    endgenerate

    // register all stages
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
            pin_out <= RST_VAL;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            pin_out <= next_out;
        end
    end

endmodule : cdi_pin_sync

// file: rtl/cdi_debounce.sv
// digital debounce filter for the card presence switch
`timescale 1ns/100ps
module cdi_debounce
    import cdi_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // synchronised raw level
    input wire logic din,
    // filtered level and change pulse
    output logic level,
    output logic changed
);

    logic [DEBOUNCE_CNT_W-1:0] stable_cnt; // cycles the new level has held
    logic [DEBOUNCE_CNT_W-1:0] next_stable_cnt;
    logic next_level;
    logic next_changed;

    // count while input differs; any return restarts the interval
    always_comb begin
        next_stable_cnt = '0;
        next_level = level;
        next_changed = 1'b0;
        if (din != level) begin
            if (stable_cnt == DEBOUNCE_CYCLES - 1'b1) begin
                // held for the full interval: accept it
                next_level = din;
                next_changed = 1'b1;
            end else begin
                next_stable_cnt = stable_cnt + 1'b1;
            end
        end
        // din equal to level: counter stays cleared, interval restarts
    end

    // register filter state; reset assumes an open switch
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stable_cnt <= '0;
            level <= PIN_RST_VAL[PIN_CARD_SW];
            changed <= 1'b0;
        end else begin
            stable_cnt <= next_stable_cnt;
            level <= next_level;
            changed <= next_changed;
        end
    end

endmodule : cdi_debounce

// file: verification/cdi_host_port_sva.sv
// concurrent checks on the card detect host port pins
`timescale 1ns/100ps
module cdi_host_port_sva
    import cdi_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host and card side inputs
    input wire logic unit_select_n,
    input wire logic program_select_n,
    input wire logic status_sel_lo,
    input wire logic status_sel_hi,
    input wire logic prog_data_in,
    input wire logic battery_ok_in,
    input wire logic converter_ok_in,
    input wire logic card_presence_switch_in,
    // device outputs
    input wire logic irq_n,
    input wire logic status_out,
    input wire logic card_present_out
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // cycles the switch pin has held its level, saturating
    logic [10:0] sw_stable;
    logic sw_prev; // last sampled switch level
    wire logic [1:0] sel = {status_sel_hi, status_sel_lo};
    // counting the pin itself keeps the check free of the sync delay
    always_ff @(posedge ref_clk) begin
        sw_prev <= card_presence_switch_in;
        if (rst || sw_prev != card_presence_switch_in) begin
            sw_stable <= 11'h0;
        end else if (sw_stable != 11'h7ff) begin
            sw_stable <= sw_stable + 11'h1;
        end
    end
    // select held low for a while with the interrupt pending
    sequence ack_held;
        (unit_select_n && !irq_n) ##1 (!unit_select_n && !irq_n)[*8];
    endsequence
    // select falls while program select is low
    sequence prog_entry;
        $fell(unit_select_n) && !program_select_n;
    endsequence
    debounce_fall_a: assert property ($fell(irq_n) |-> $past(sw_stable, 4) >= 11'h3de)
        else $error("interrupt before the switch settled");
    ack_release_a: assert property (ack_held ##[1:20] $rose(unit_select_n) |-> ##[4:6] irq_n)
        else $error("interrupt not released after select rise");
    release_cause_a: assert property ($rose(irq_n) |->
        $past(unit_select_n, 4) && !$past(unit_select_n, 7))
        else $error("interrupt released without a select cycle");
    status_presence_a: assert property ((!unit_select_n && program_select_n &&
        sel == SEL_PRESENCE && $stable(card_present_out))[*8] |->
        status_out == card_present_out)
        else $error("status does not show presence");
    status_battery_a: assert property ((!unit_select_n && program_select_n &&
        sel == SEL_BATTERY && $stable(battery_ok_in))[*8] |-> status_out == battery_ok_in)
        else $error("status does not show battery result");
    status_conv_a: assert property ((!unit_select_n && program_select_n &&
        sel == SEL_CONVERTER && $stable(converter_ok_in))[*8] |->
        status_out == converter_ok_in)
        else $error("status does not show converter result");
    prog_hold_a: assert property (prog_entry |-> ##6 $stable(status_out)[*4])
        else $error("status moved in programming mode");
    presence_cause_a: assert property ($changed(card_present_out) |->
        !irq_n || ($past(unit_select_n, 5) && !$past(unit_select_n, 8)))
        else $error("presence changed without event or programming");
endmodule : cdi_host_port_sva

bind cdi_host_port cdi_host_port_sva u_sva (.ref_clk, .rst, .unit_select_n, .program_select_n,
    .status_sel_lo, .status_sel_hi, .prog_data_in, .battery_ok_in, .converter_ok_in,
    .card_presence_switch_in, .irq_n, .status_out, .card_present_out);

// file: verification/cdi_host_model.sv
// host controller model driving select, program and address pins
`timescale 1ns/100ps
module cdi_host_model (
    // clock and device status
    input wire logic ref_clk,
    input wire logic status_out,
    // host control pins
    output logic unit_select_n,
    output logic program_select_n,
    output logic status_sel_lo,
    output logic status_sel_hi,
    output logic prog_data_in,
    // sampled status and its one cycle strobe
    output logic rd_bit,
    output logic rd_valid
);
    // idle host: deselected, normal mode
    initial begin
        unit_select_n = 1'b1;
        program_select_n = 1'b1;
        {status_sel_hi, status_sel_lo} = 2'h0;
        prog_data_in = 1'b0;
        rd_bit = 1'b0;
        rd_valid = 1'b0;
    end
    // one select cycle; a read doubles as interrupt acknowledge
    task access(input logic prog, input logic [1:0] addr, input logic dat);
        @(negedge ref_clk);
        {status_sel_hi, status_sel_lo} = addr;
        program_select_n = !prog;
        prog_data_in = dat;
        unit_select_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        program_select_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        rd_bit = status_out;
        rd_valid = !prog;
        @(negedge ref_clk);
        rd_valid = 1'b0;
        unit_select_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        // released lines show garbage, not the last value
        {status_sel_hi, status_sel_lo} = ~addr;
        prog_data_in = !dat;
    endtask : access
endmodule : cdi_host_model

// file: verification/test_cdi_host_port.sv
// self-checking bench for the card detect interrupt host port
`timescale 1ns/100ps
module test_cdi_host_port;
    import cdi_pkg::*;
    // clock, reset and bench driven pins
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic batt = 1'b0;
    logic conv = 1'b0;
    logic sw = 1'b1; // switch open
    // host pins and device outputs
    logic unit_select_n, program_select_n, status_sel_lo, status_sel_hi, prog_data_in;
    logic irq_n, status_out, card_present_out, rd_bit, rd_valid;
    // scoreboard and random state
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'hcfea700b;
    logic [31:0] r;
    logic exp_q[$];
    always #25 ref_clk = ~ref_clk;
    cdi_host_port uut (.ref_clk, .rst, .unit_select_n, .program_select_n, .status_sel_lo,
        .status_sel_hi, .prog_data_in, .battery_ok_in(batt), .converter_ok_in(conv),
        .card_presence_switch_in(sw), .irq_n, .status_out, .card_present_out);
    cdi_host_model host (.ref_clk, .status_out, .unit_select_n, .program_select_n,
        .status_sel_lo, .status_sel_hi, .prog_data_in, .rd_bit, .rd_valid);
    // xorshift source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task chk(input string nm, input logic e, input logic s);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %b seen %b", nm, e, s);
        end
    endtask : chk
    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // each host read is matched to the oldest note
    always @(posedge ref_clk) begin
        if (rd_valid === 1'b1) begin
            chk("status read", exp_q.pop_front(), rd_bit);
        end
    end
    // hang guard, well above the fewer than eight thousand cycles used
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            stop_test();
        end
    end
    task wait_irq(input logic lvl, input int lim);
        for (int i = 0; i < lim && irq_n !== lvl; i++) begin
            @(negedge ref_clk);
        end
    endtask : wait_irq
    // move the switch, expect silence through the filter, then the event
    task card_step(input logic lvl, input logic pres);
        @(negedge ref_clk);
        sw = lvl;
        repeat (990) @(negedge ref_clk);
        chk("irq early", 1'b1, irq_n);
        wait_irq(1'b0, 40);
        chk("irq", 1'b0, irq_n);
        chk("present", pres, card_present_out);
    endtask : card_step
    task read(input logic [1:0] a, input logic e);
        exp_q.push_back(e);
        host.access(1'b0, a, 1'b0);
    endtask : read
    initial begin
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk("irq reset", 1'b1, irq_n);
        chk("present reset", 1'b0, card_present_out);
        $display("test reset done");
        // bounces shorter than the filter leave no trace
        for (int i = 0; i < 3; i++) begin
            r = xs();
            sw = 1'b0;
            repeat (10 + r % 900) @(negedge ref_clk);
            sw = 1'b1;
            repeat (20) @(negedge ref_clk);
        end
        repeat (1100) @(negedge ref_clk);
        chk("irq bounce", 1'b1, irq_n);
        $display("test bounce done");
        card_step(1'b0, 1'b1);
        read(SEL_PRESENCE, 1'b1);
        repeat (8) @(negedge ref_clk);
        chk("irq ack", 1'b1, irq_n);
        $display("test insert done");
        // addresses 1, 2, 3 twice each; code three shows presence, a card is in
        for (int i = 1; i < 7; i++) begin
            r = xs();
            batt = r[0];
            conv = r[1];
            read(2'(i % 3 + 1), i % 3 == 0 ? batt : (i % 3 == 1 ? conv : 1'b1));
        end
        $display("test sources done");
        // rising edge polarity, program select dropped mid cycle
        host.access(1'b1, PROG_ADDR_POLARITY, 1'b1);
        // other programming addresses must leave the polarity alone
        host.access(1'b1, SEL_BATTERY, 1'b0);
        repeat (4) @(negedge ref_clk);
        chk("present prog", 1'b0, card_present_out);
        chk("irq prog", 1'b1, irq_n);
        read(SEL_PRESENCE, 1'b0);
        $display("test program done");
        card_step(1'b1, 1'b1);
        read(SEL_PRESENCE, 1'b1);
        card_step(1'b0, 1'b0);
        read(SEL_PRESENCE, 1'b0);
        repeat (8) @(negedge ref_clk);
        chk("irq clear", 1'b1, irq_n);
        $display("test extract done");
        stop_test();
    end
endmodule : test_cdi_host_port
